// File: logic/cbx_pkg.sv
package cbx_pkg;
  // Register map, word addresses on the plain port
  localparam logic [4:0] ADDR_CTRL_ONE   = 5'h00;  // serial_control_one
  localparam logic [4:0] ADDR_CTRL_TWO   = 5'h01;  // serial_control_two
  localparam logic [4:0] ADDR_WORD_COUNT = 5'h02;  // word_count_register
  localparam logic [4:0] ADDR_STATUS     = 5'h03;  // serial_status_register
  localparam logic [4:0] ADDR_DATA_BASE  = 5'h10;  // shared_data_area, 16 addresses, DEPTH slots
  // serial_control_one fields
  localparam int CTRL_START_POS  = 7;
  localparam int CTRL_ABORT_POS  = 6;
  localparam int CTRL_MODE_HI    = 5;
  localparam int CTRL_MODE_LO    = 3;
  localparam int CTRL_EXTCLK_POS = 0;
  // serial_control_two fields
  localparam int CTRL2_DIV_HI = 1;
  localparam int CTRL2_DIV_LO = 0;
  // Status fields
  localparam int STAT_ACTIVE_POS = 7;
  localparam int STAT_WAIT_POS   = 6;
  localparam logic [7:0] CTRL_ONE_RST   = 8'h00;
  localparam logic [7:0] CTRL_TWO_RST   = 8'h00;
  localparam logic [2:0] WORD_COUNT_RST = 3'h0;
  // Transfer modes in xfer_mode_field
  typedef enum logic [2:0] {
    CBX_MODE_TX8  = 3'b000,
    CBX_MODE_TX4  = 3'b001,
    CBX_MODE_TXRX = 3'b010,
    CBX_MODE_RX8  = 3'b110,
    CBX_MODE_RX4  = 3'b111
  } cbx_mode_t;
  typedef enum logic [1:0] {
    CBX_IDLE  = 2'b00,
    CBX_SHIFT = 2'b01,
    CBX_WAIT  = 2'b10,
    CBX_LAST  = 2'b11
  } cbx_state_t;
  // Internal half-period choices in core cycles (base rate, shifted by divider)
  localparam int SCK_HALF_NS     = 80;
  localparam int CLK_PERIOD_NS   = 8;
  localparam int SCK_HALF_CYCLES = SCK_HALF_NS / CLK_PERIOD_NS;
endpackage

// File: logic/cbx_serial_xfer.sv
// Added by the designer: the address map and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
module cbx_serial_xfer #(
  parameter int DEPTH = 8
) (
  // Clock and reset
  input  wire logic       core_clk_in,
  input  wire logic       arst_n_in,
  // Register port
  input  wire logic [4:0] reg_addr_in,
  input  wire logic [7:0] reg_wdata_in,
  input  wire logic       reg_wr_in,
  input  wire logic       reg_rd_in,
  output logic      [7:0] reg_rdata_out,
  // Serial pins
  input  wire logic       sck_in,
  output logic            sck_out,
  output logic            sck_oe_out,
  input  wire logic       sdi_in,
  output logic            sdo_out,
  // Event
  output logic            serial_buffer_irq_out
);
  typedef struct packed {
    // Software-visible registers
    logic [7:0]       ctrl1;
    logic [1:0]       ctrl2;
    logic [2:0]       count;
    // Data buffer
    logic [DEPTH-1:0][7:0] buf_q;
    // Shift engine
    cbx_pkg::cbx_state_t st;
    logic [7:0]       shreg;
    logic [3:0]       bitn;
    logic [2:0]       idx;
    logic             dummy;
    logic             rx_got;
    logic             tx_got;
    // Internal clock and data-out
    logic             sck_o;
    logic             sdo;
    logic [7:0]       div;
    // Pin synchronisers and edge history
    logic [1:0]       sck_s;
    logic [1:0]       sdi_s;
    logic             sck_d;
    // Registered outputs
    logic             irq;
    logic [7:0]       rdata;
  } cbx_regs_t;

  cbx_regs_t r;
  cbx_regs_t n;

  // Receive-only modes
  function automatic logic is_rx(input logic [2:0] m);
    is_rx = (m == cbx_pkg::CBX_MODE_RX8) || (m == cbx_pkg::CBX_MODE_RX4);
  endfunction

  // Every mode that drives the data-out pin, duplex included
  function automatic logic is_tx(input logic [2:0] m);
    is_tx = !is_rx(m);
  endfunction

  // The shared transmit/receive mode
  function automatic logic is_duplex(input logic [2:0] m);
    is_duplex = (m == cbx_pkg::CBX_MODE_TXRX);
  endfunction

  // Modes that capture the data-in pin
  function automatic logic takes_in(input logic [2:0] m);
    takes_in = is_rx(m) || is_duplex(m);
  endfunction

  // Data-area address: upper half of the map
  function automatic logic data_addr(input logic [4:0] a);
    data_addr = a[4];
  endfunction

  // Data-area address that names a real buffer entry
  function automatic logic slot_addr(input logic [4:0] a);
    slot_addr = a[4] && (a[3:0] < 4'(DEPTH));
  endfunction

  // Completed receive word as it lands in the buffer
  function automatic logic [7:0] rx_word(input logic [2:0] m, input logic b,
                                         input logic [7:0] s);
    if (m == cbx_pkg::CBX_MODE_TXRX) begin
      rx_word = {b, s[6:0]};
    end else if (m == cbx_pkg::CBX_MODE_RX4) begin
      rx_word = {4'h0, b, s[7:5]};
    end else begin
      rx_word = {b, s[7:1]};
    end
  endfunction

  // Decoded control and strobes
  logic [2:0] mode;
  logic       four_bit;
  logic       ext_clk;
  logic       fall_e;
  logic       rise_e;
  logic       data_hit;
  logic       slot_hit;
  logic [3:0] word_bits;
  logic [7:0] half_cnt;
  logic [7:0] status_byte;
  logic       resume;

  always_comb begin
    mode      = r.ctrl1[cbx_pkg::CTRL_MODE_HI:cbx_pkg::CTRL_MODE_LO];
    four_bit  = (mode == cbx_pkg::CBX_MODE_TX4) || (mode == cbx_pkg::CBX_MODE_RX4);
    ext_clk   = r.ctrl1[cbx_pkg::CTRL_EXTCLK_POS];
    word_bits = four_bit ? 4'h4 : 4'h8;
    data_hit  = data_addr(reg_addr_in);
    slot_hit  = slot_addr(reg_addr_in);
    half_cnt  = 8'(cbx_pkg::SCK_HALF_CYCLES << r.ctrl2);
    fall_e    = 1'b0;
    rise_e    = 1'b0;
    n         = r;
    // Interrupt is a one-cycle pulse
    n.irq     = 1'b0;

    // Pin synchronisers
    n.sck_s   = {r.sck_s[0], sck_in};
    n.sdi_s   = {r.sdi_s[0], sdi_in};
    n.sck_d   = r.sck_s[1];

    // Edge source: external pin or internal divider
    if (ext_clk) begin
      fall_e = r.sck_d && !r.sck_s[1];
      rise_e = !r.sck_d && r.sck_s[1];
    end else if (r.st == cbx_pkg::CBX_SHIFT || r.st == cbx_pkg::CBX_LAST) begin
      // One toggle per half period, scaled by the divider field
      if (r.div >= half_cnt - 8'h01) begin
        n.div   = 8'h00;
        n.sck_o = !r.sck_o;
        fall_e  = r.sck_o;
        rise_e  = !r.sck_o;
      end else begin
        n.div = r.div + 8'h01;
      end
    end

    // Register writes
    n.rdata = r.rdata;
    if (reg_wr_in) begin
      if (data_hit) begin
        if (slot_hit) begin
          n.buf_q[reg_addr_in[2:0]] = reg_wdata_in;
        end
        n.tx_got = 1'b1;
      end else if (reg_addr_in == cbx_pkg::ADDR_CTRL_ONE) begin
        // A mode change empties the buffer, so stale words never go out
        if (reg_wdata_in[cbx_pkg::CTRL_MODE_HI:cbx_pkg::CTRL_MODE_LO] != mode) begin
          n.buf_q = '0;
        end
        n.ctrl1 = reg_wdata_in;
      end else if (reg_addr_in == cbx_pkg::ADDR_CTRL_TWO) begin
        n.ctrl2 = reg_wdata_in[cbx_pkg::CTRL2_DIV_HI:cbx_pkg::CTRL2_DIV_LO];
      end else if (reg_addr_in == cbx_pkg::ADDR_WORD_COUNT) begin
        n.count = reg_wdata_in[2:0];
      end
    end

    // Register reads, data one cycle later
    if (reg_rd_in) begin
      if (data_hit) begin
        n.rdata  = slot_hit ? r.buf_q[reg_addr_in[2:0]] : 8'h00;
        n.rx_got = 1'b1;
      end else if (reg_addr_in == cbx_pkg::ADDR_CTRL_ONE) begin
        n.rdata = r.ctrl1;
      end else if (reg_addr_in == cbx_pkg::ADDR_WORD_COUNT) begin
        n.rdata = {5'h00, r.count};
      end else if (reg_addr_in == cbx_pkg::ADDR_STATUS) begin
        n.rdata = status_byte;
      end else begin
        n.rdata = 8'h00;
      end
    end

    // Transfer engine
    case (r.st)
      cbx_pkg::CBX_IDLE: begin
        n.sck_o = 1'b1;
        n.div   = 8'h00;
        // Abort must be cleared by software before a start takes
        if (r.ctrl1[cbx_pkg::CTRL_START_POS] && !r.ctrl1[cbx_pkg::CTRL_ABORT_POS]) begin
          n.st     = cbx_pkg::CBX_SHIFT;
          n.idx    = 3'h0;
          n.bitn   = 4'h0;
          n.shreg  = r.buf_q[0];
          n.dummy  = 1'b0;
          n.tx_got = reg_wr_in && data_hit;
          n.rx_got = reg_rd_in && data_hit;
        end
      end
      cbx_pkg::CBX_SHIFT, cbx_pkg::CBX_LAST: begin
        if (fall_e && is_tx(mode)) begin
          n.sdo   = r.shreg[0];
          n.shreg = {1'b0, r.shreg[7:1]};
        end
        if (rise_e) begin
          // Receive shifts right; duplex fills the top bit freed at the falling edge
          if (is_rx(mode)) begin
            n.shreg = {r.sdi_s[1], r.shreg[7:1]};
          end else if (is_duplex(mode)) begin
            n.shreg = {r.sdi_s[1], r.shreg[6:0]};
          end
          n.bitn = r.bitn + 4'h1;
          if (r.bitn + 4'h1 == word_bits) begin
            n.bitn = 4'h0;
            if (takes_in(mode)) begin
              if (r.dummy && is_rx(mode) && ext_clk) begin
                n.st = cbx_pkg::CBX_IDLE;
                n.ctrl1[cbx_pkg::CTRL_START_POS] = 1'b0;
              end else begin
                n.buf_q[r.idx] = rx_word(mode, r.sdi_s[1], r.shreg);
              end
            end
            if (!r.ctrl1[cbx_pkg::CTRL_START_POS] || r.st == cbx_pkg::CBX_LAST) begin
              n.st = cbx_pkg::CBX_IDLE;
            end else if (r.idx == r.count) begin
              // Count reached: stall the internal clock, or arm the refill check
              n.irq    = 1'b1;
              n.idx    = 3'h0;
              // An access in this very cycle still counts: set wins over clear
              n.tx_got = reg_wr_in && data_hit;
              n.rx_got = reg_rd_in && data_hit;
              if (ext_clk) begin
                n.dummy = 1'b1;
                n.shreg = r.buf_q[0];
              end else begin
                n.st = cbx_pkg::CBX_WAIT;
              end
            end else begin
              n.idx   = r.idx + 3'h1;
              n.shreg = r.buf_q[r.idx + 3'h1];
            end
          end
        end

        // External clock: refill missing at next shift
        if (ext_clk && r.dummy && fall_e && r.bitn == 4'h0) begin
          if (is_rx(mode)) begin
            n.dummy = r.rx_got ? 1'b0 : 1'b1;
          end else if (!(r.tx_got || reg_wr_in)) begin
            n.st = cbx_pkg::CBX_LAST;
          end else begin
            n.dummy = 1'b0;
          end
        end
        // A read at any time lifts the receive hold
        if (ext_clk && r.dummy && is_rx(mode) && r.rx_got) begin
          n.dummy = 1'b0;
        end
      end
      cbx_pkg::CBX_WAIT: begin
        n.sck_o = 1'b1;
        if (!r.ctrl1[cbx_pkg::CTRL_START_POS]) begin
          n.st = cbx_pkg::CBX_IDLE;
        end else if (resume) begin
          n.st    = cbx_pkg::CBX_SHIFT;
          n.shreg = r.buf_q[0];
          n.div   = 8'h00;
        end
      end
      default: n.st = cbx_pkg::CBX_IDLE;
    endcase

    // Abort ends at once
    if (r.ctrl1[cbx_pkg::CTRL_ABORT_POS]) begin
      n.st    = cbx_pkg::CBX_IDLE;
      n.sck_o = 1'b1;
      n.irq   = 1'b0;
    end
  end

  // Status byte as software sees it
  always_comb begin
    status_byte = 8'h00;
    status_byte[cbx_pkg::STAT_ACTIVE_POS] = (r.st != cbx_pkg::CBX_IDLE);
    status_byte[cbx_pkg::STAT_WAIT_POS]   = (r.st == cbx_pkg::CBX_WAIT);
  end

  // Wait release: a data read in receive modes, a data write in the others
  always_comb begin
    resume = 1'b0;
    if (is_rx(mode)) begin
      resume = r.rx_got;
    end else begin
      resume = r.tx_got;
    end
  end

  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      r       <= '0;
      r.ctrl1 <= cbx_pkg::CTRL_ONE_RST;
      r.ctrl2 <= cbx_pkg::CTRL_TWO_RST[1:0];
      r.count <= cbx_pkg::WORD_COUNT_RST;
      // Clock and synchroniser start idle high, so no false edge follows reset
      r.sck_o <= 1'b1;
      r.sdo   <= 1'b1;
      r.sck_s <= 2'b11;
      r.sck_d <= 1'b1;
    end else begin
      r <= n;
    end
  end

  always_comb begin
    reg_rdata_out         = r.rdata;
    sck_out               = r.sck_o;
    // The clock pin is driven only while the internal clock is selected
    sck_oe_out            = !ext_clk;
    sdo_out               = r.sdo;
    serial_buffer_irq_out = r.irq;
  end
endmodule
`default_nettype wire

// File: tb/cbx_link_partner.sv
`timescale 1ns/1ps
`default_nettype none
module cbx_link_partner (
  input  wire logic        sck_in,
  input  wire logic        sdo_in,
  input  wire logic [7:0]  tx_word_in,
  output logic             sck_drv_out,
  output logic             sdi_out,
  output logic      [15:0] rx_bits_out
);
  int k;
  initial begin
    sck_drv_out = 1'b1;
    sdi_out = 1'b1;
    rx_bits_out = '0;
    k = 0;
  end
  // Take device data on rising edge, LSB arrives first
  always @(posedge sck_in) rx_bits_out <= {sdo_in, rx_bits_out[15:1]};
  // Offer own bits on falling edge, LSB first
  always @(negedge sck_in) begin
    sdi_out <= tx_word_in[k % 8];
    k <= k + 1;
  end
  // External clock, 80 ns phases stay above four core cycles
  task automatic clock_bits(input int n);
    repeat (n) begin
      #80 sck_drv_out = 1'b0;
      #80 sck_drv_out = 1'b1;
    end
  endtask
endmodule
`default_nettype wire

// File: tb/cbx_serial_xfer_checker.sv
`timescale 1ns/1ps
`default_nettype none
module cbx_serial_xfer_checker (
  input wire logic       core_clk_in,
  input wire logic       arst_n_in,
  input wire logic [4:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic       reg_wr_in,
  input wire logic       reg_rd_in,
  input wire logic [7:0] reg_rdata_out,
  input wire logic       sck_in,
  input wire logic       sck_out,
  input wire logic       sck_oe_out,
  input wire logic       sdi_in,
  input wire logic       sdo_out,
  input wire logic       serial_buffer_irq_out
);
  logic      abort_r;
  wire logic ctl_wr  = reg_wr_in && reg_addr_in == cbx_pkg::ADDR_CTRL_ONE;
  wire logic ext_bit = reg_wdata_in[cbx_pkg::CTRL_EXTCLK_POS];
  // Last abort bit written by software
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      abort_r <= 1'b0;
    end else if (ctl_wr) begin
      abort_r <= reg_wdata_in[cbx_pkg::CTRL_ABORT_POS];
    end
  end
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!arst_n_in);
  a_irq_one_pulse: assert property (serial_buffer_irq_out |=> !serial_buffer_irq_out)
    else $error("irq pulse longer than one cycle");
  a_rdata_holds: assert property (!reg_rd_in |=> $stable(reg_rdata_out))
    else $error("read data changed without a read");
  a_unmapped_zero: assert property (reg_rd_in && reg_addr_in inside {[5'h04:5'h0F]}
    |=> reg_rdata_out == 8'h00) else $error("unmapped read not zero");
  a_oe_follows: assert property (ctl_wr |=> sck_oe_out == !$past(ext_bit))
    else $error("clock drive enable does not follow clock source");
  a_sck_high_min: assert property ($rose(sck_out) |-> sck_out [*8])
    else $error("internal clock high phase too short");
  a_sdo_hold: assert property (sck_oe_out && !abort_r && sck_out && $past(sck_out)
    |-> $stable(sdo_out)) else $error("data out changed while clock high");
  a_status_abort: assert property (reg_rd_in && reg_addr_in == cbx_pkg::ADDR_STATUS
    && abort_r && $past(abort_r) |=> !reg_rdata_out[cbx_pkg::STAT_ACTIVE_POS])
    else $error("active flag set while aborted");
  a_irq_aborted: assert property (abort_r && $past(abort_r) |-> !serial_buffer_irq_out)
    else $error("irq while aborted");
endmodule
bind cbx_serial_xfer cbx_serial_xfer_checker i_chk (
  .core_clk_in(core_clk_in), .arst_n_in(arst_n_in), .reg_addr_in(reg_addr_in),
  .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
  .reg_rdata_out(reg_rdata_out), .sck_in(sck_in), .sck_out(sck_out),
  .sck_oe_out(sck_oe_out), .sdi_in(sdi_in), .sdo_out(sdo_out),
  .serial_buffer_irq_out(serial_buffer_irq_out));
`default_nettype wire

// File: tb/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic        clk, rst_n, wr_s, rd_s, sck_o, sck_oe, sdi, sdo, irq, sck_drv;
  logic [4:0]  addr;
  logic [7:0]  wdata, rdata, rv, ptx;
  logic [15:0] prx;
  wire logic   sck_w = sck_oe ? sck_o : sck_drv;
  int          n_mismatch, checks;
  cbx_serial_xfer i_cbx_serial_xfer (.core_clk_in(clk), .arst_n_in(rst_n),
    .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr_s), .reg_rd_in(rd_s),
    .reg_rdata_out(rdata), .sck_in(sck_w), .sck_out(sck_o), .sck_oe_out(sck_oe),
    .sdi_in(sdi), .sdo_out(sdo), .serial_buffer_irq_out(irq));
  cbx_link_partner i_cbx_link_partner (.sck_in(sck_w), .sdo_in(sdo), .tx_word_in(ptx),
    .sck_drv_out(sck_drv), .sdi_out(sdi), .rx_bits_out(prx));
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_s <= 1'b1;
    @(posedge clk);
    wr_s <= 1'b0;
  endtask
  task automatic rd(input logic [4:0] a);
    @(posedge clk);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    #1 rv = rdata;
  endtask
  task automatic ctl(input logic s, input logic ab, input cbx_pkg::cbx_mode_t m, input logic e);
    wr(cbx_pkg::ADDR_CTRL_ONE, {s, ab, m, 2'b00, e});
  endtask
  task automatic wait_irq;
    repeat (4000) begin
      @(posedge clk);
      #1;
      if (irq === 1'b1) break;
    end
    chk("irq", {7'h00, irq}, 8'h01);
  endtask
  task automatic t_tx8;
    ctl(1'b0, 1'b0, cbx_pkg::CBX_MODE_TX8, 1'b0);
    wr(cbx_pkg::ADDR_WORD_COUNT, 8'h01);
    wr(cbx_pkg::ADDR_DATA_BASE, 8'hA5);
    wr(cbx_pkg::ADDR_DATA_BASE + 5'h01, 8'h3C);
    ctl(1'b1, 1'b0, cbx_pkg::CBX_MODE_TX8, 1'b0);
    wait_irq();
    chk("tx word 0", prx[7:0], 8'hA5);
    chk("tx word 1", prx[15:8], 8'h3C);
    rd(cbx_pkg::ADDR_STATUS);
    chk("tx wait status", rv & 8'hC0, 8'hC0);
    repeat (40) @(posedge clk);
    chk("sck stalled", {7'h00, sck_o}, 8'h01);
    chk("sdo hold", {7'h00, sdo}, 8'h00);
    ctl(1'b0, 1'b0, cbx_pkg::CBX_MODE_TX8, 1'b0);
    repeat (30) @(posedge clk);
    rd(cbx_pkg::ADDR_STATUS);
    chk("tx ended", rv & 8'h80, 8'h00);
    $display("test tx8 done");
  endtask
  task automatic t_rx4_abort;
    ptx = 8'hB6;
    ctl(1'b0, 1'b0, cbx_pkg::CBX_MODE_RX4, 1'b0);
    wr(cbx_pkg::ADDR_WORD_COUNT, 8'h00);
    ctl(1'b1, 1'b0, cbx_pkg::CBX_MODE_RX4, 1'b0);
    wait_irq();
    rd(cbx_pkg::ADDR_DATA_BASE);
    chk("rx4 word", rv, 8'h06);
    ctl(1'b0, 1'b1, cbx_pkg::CBX_MODE_RX4, 1'b0);
    rd(cbx_pkg::ADDR_STATUS);
    chk("abort status", rv & 8'h80, 8'h00);
    ctl(1'b0, 1'b0, cbx_pkg::CBX_MODE_RX4, 1'b0);
    $display("test rx4 abort done");
  endtask
  task automatic t_duplex_ext;
    i_cbx_link_partner.k = 0;
    ptx = 8'hC3;
    ctl(1'b0, 1'b0, cbx_pkg::CBX_MODE_TXRX, 1'b1);
    wr(cbx_pkg::ADDR_WORD_COUNT, 8'h00);
    wr(cbx_pkg::ADDR_DATA_BASE, 8'h5A);
    ctl(1'b1, 1'b0, cbx_pkg::CBX_MODE_TXRX, 1'b1);
    fork
      i_cbx_link_partner.clock_bits(8);
      wait_irq();
    join
    chk("duplex out", prx[15:8], 8'h5A);
    rd(cbx_pkg::ADDR_DATA_BASE);
    chk("duplex in", rv, 8'hC3);
    ctl(1'b0, 1'b0, cbx_pkg::CBX_MODE_TXRX, 1'b1);
    $display("test duplex ext done");
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  initial begin
    {rst_n, wr_s, rd_s, addr, wdata, ptx} = '0;
    n_mismatch = 0;
    checks = 0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    rd(5'h05);
    chk("unmapped", rv, 8'h00);
    rd(cbx_pkg::ADDR_STATUS);
    chk("idle status", rv, 8'h00);
    t_tx8();
    t_rx4_abort();
    t_duplex_ext();
    tally_and_finish();
  end
  initial begin
    #100000;
    n_mismatch++;
    tally_and_finish();
  end
endmodule
`default_nettype wire
